// ---- pkg/bsid_pkg.sv ----
// Shared constants, types and helpers for the board status and id bank.
package bsid_pkg;

  // Byte offsets of the registers on the register bus.
  localparam logic [11:0] BSID_OFS_SWITCH   = 12'h00C; // Switch mirror.
  localparam logic [11:0] BSID_OFS_REV      = 12'h010; // Board revision.
  localparam logic [11:0] BSID_OFS_LOCK     = 12'h100; // Loop lock status.
  localparam logic [11:0] BSID_OFS_BUILD    = 12'hFF8; // Build id.
  localparam logic [11:0] BSID_OFS_IRQ_STAT = 12'h200; // Event status.
  localparam logic [11:0] BSID_OFS_IRQ_MASK = 12'h204; // Event mask.

  // Field positions inside the loop lock status register.
  localparam int BSID_LOCK_MASK_LSB = 24; // Mask bits [31:24].
  localparam int BSID_LOCK_FLAG_LSB = 16; // Lock flags [23:16].
  localparam int BSID_LOCK_COMB_BIT = 0;  // Combined lock flag [0].

  // Field positions inside the build identification register.
  localparam int BSID_BUILD_NUM_LSB = 24; // Build number [31:24].
  localparam int BSID_BUILD_REV_LSB = 20; // Target revision [23:20].
  localparam int BSID_BUILD_CAP_LSB = 8;  // Capability flags [10:8].
  localparam int BSID_BUILD_CNT_LSB = 0;  // Register count [7:0].

  // Values after reset and fixed build fields.
  localparam logic [7:0] BSID_RST_MASK      = 8'hFF; // All loops counted.
  localparam logic [7:0] BSID_BUILD_NUM     = 8'h03; // Build number.
  localparam logic [3:0] BSID_BUILD_REV     = 4'h1;  // Targets revision B.
  localparam logic [2:0] BSID_BUILD_CAPS    = 3'h7;  // All queries present.
  localparam logic [7:0] BSID_BUILD_CNT     = 8'h08; // User registers.
  localparam logic [7:0] BSID_BUILD_CNT_MAX = 8'h08; // Upper bound.

  // Board revision codes.
  localparam logic [3:0] BSID_REV_A = 4'h0; // Revision A.
  localparam logic [3:0] BSID_REV_B = 4'h1; // Revision B.
  localparam logic [3:0] BSID_REV_C = 4'h2; // Revision C.

  // Event bit positions in the status and mask registers.
  localparam int BSID_IRQ_W        = 3; // Number of event bits.
  localparam int BSID_EV_LOCK_LOST = 0; // Combined flag fell.
  localparam int BSID_EV_LOCK_GAIN = 1; // Combined flag rose.
  localparam int BSID_EV_SWITCH    = 2; // Switch mirror changed.

  // Phases of the strap capture after reset release.
  typedef enum logic [1:0] {
    BSID_REV_WAIT1,
    BSID_REV_WAIT2,
    BSID_REV_WAIT3,
    BSID_REV_HELD
  } bsid_rev_st_t;

  // State of the register bank outside the event unit and the synchronisers.
  typedef struct packed {
    logic [7:0]   sw;      // Mirrored switch levels.
    logic [3:0]   rev;     // Captured board revision.
    bsid_rev_st_t rev_st;  // Strap capture phase.
    logic [7:0]   mask;    // Loop lock mask bits.
    logic         comb;    // Combined lock flag.
    logic [31:0]  prdata;  // Read data to the bus.
    logic         pready;  // Transfer completion.
    logic         pslverr; // Unmapped address answer.
  } bsid_state_t;

  // Whole state of the event unit.
  typedef struct packed {
    logic [BSID_IRQ_W-1:0] status; // Sticky event bits.
    logic [BSID_IRQ_W-1:0] mask;   // Event enables.
    logic                  irq;    // Interrupt level.
  } bsid_irq_state_t;

  // True when a word address matches a register offset.
  function automatic logic bsid_hit(input logic [11:0] addr,
                                    input logic [11:0] ofs);
    bsid_hit = (addr[11:2] == ofs[11:2]);
  endfunction

endpackage

// ---- tb/bsid_mgmt_model.sv ----
// Board management controller model that polls the panel switches.
`timescale 1ns/1ps
module bsid_mgmt_model #(
  parameter int POLL = 16 // Cycles between two switch polls.
) (
  input  wire logic       pclk,            // System clock.
  input  wire logic       presetn,         // Async reset, active low.
  input  wire logic [7:0] panel_levels,    // Physical switch levels.
  output logic            mc_sw_we,        // Update strobe, one cycle.
  output logic      [7:0] mc_toggle_levels // Levels handed with strobe.
);
  localparam logic [7:0] LAST = 8'(POLL - 1); // Last count of a period.
  logic [7:0] cnt_ff;  // Poll period counter.
  logic [7:0] last_ff; // Levels taken at the last poll.

  // Polls the switches once a period and writes them in with a strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= 8'h00;
      last_ff  <= 8'h00;
      mc_sw_we <= 1'b0;
    end else begin
      mc_sw_we <= (cnt_ff == LAST);
      cnt_ff   <= (cnt_ff == LAST) ? 8'h00 : cnt_ff + 8'h01;
      if (cnt_ff == LAST) begin
        last_ff <= panel_levels;
      end
    end
  end

  // Outside the strobe the data lines show the inverse, not stale data.
  assign mc_toggle_levels = mc_sw_we ? last_ff : ~last_ff;
endmodule

// ---- tb/test_bsid_regs.sv ----
// Self-checking testbench for the board status and id register bank.
`timescale 1ns/1ps
module test_bsid_regs
  import bsid_pkg::*;
;
  localparam int POLL  = 16;    // Controller poll period in cycles.
  localparam int LIMIT = 20000; // Cycle ceiling for the whole run.
  logic        pclk;       // System clock.
  logic        presetn;    // Reset, active low.
  logic        psel;       // APB select.
  logic        penable;    // APB access phase.
  logic        pwrite;     // APB direction.
  logic [11:0] paddr;      // APB address.
  logic [31:0] pwdata;     // APB write data.
  logic [31:0] prdata;     // APB read data.
  logic        pready;     // APB done.
  logic        pslverr;    // APB error.
  logic        mc_sw_we;   // Controller strobe.
  logic [7:0]  mc_levels;  // Controller switch levels.
  logic [7:0]  panel;      // Physical switch levels.
  logic [7:0]  loops;      // Loop lock levels.
  logic        irq;        // Interrupt level.
  logic        comb_flag;  // Combined lock pin.
  logic        pce;        // Clock enable.
  logic [3:0]  strap;      // Board revision straps.
  int          n_mismatch; // Mismatches seen.
  int          check_count; // Comparisons made.
  int          cycles;     // Cycles run.
  logic [31:0] rdv;        // Scratch read data.
  logic        erv;        // Scratch error flag.
  logic [7:0]  m_tab [5] = '{8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h0F}; // Masks.
  logic [7:0]  l_tab [5] = '{8'hFF, 8'hFE, 8'hFE, 8'h00, 8'hF0}; // Locks.
  logic [11:0] ro_tab [3] = '{BSID_OFS_SWITCH, BSID_OFS_REV, BSID_OFS_BUILD};
  // Write data that touches defined fields only.
  logic [31:0] ro_wd [3] = '{32'h000000FF, 32'h0000000F, 32'hFFF007FF};
  logic [31:0] build_exp; // Expected build word.

  bsid_regs dut_u (.pclk(pclk), .presetn(presetn), .pce(pce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mc_sw_we(mc_sw_we), .mc_toggle_levels(mc_levels),
    .loop_locked(loops), .board_rev_strap(strap), .irq(irq),
    .combined_lock_flag(comb_flag));

  bsid_mgmt_model #(.POLL(POLL)) mgmt_u (.pclk(pclk), .presetn(presetn),
    .panel_levels(panel), .mc_sw_we(mc_sw_we), .mc_toggle_levels(mc_levels));

  // Free-running clock at 25 MHz.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compares one value with its expectation and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the cycle ceiling ends a hung wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Write with the error flag checked against the expectation.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic eexp);
    apb(1'b1, a, d, rdv, erv);
    check({31'h0, erv}, {31'h0, eexp});
  endtask

  // Read compared with an expected word and no error.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rdv, erv);
    check(rdv, exp);
    check({31'h0, erv}, 32'h0);
  endtask

  // Resets the bank for four cycles and lets the strap capture settle.
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // Cycle ceiling against a hung run.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  // Main sequence of scenarios.
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    panel = 8'h00;
    loops = 8'hFF;
    pce = 1'b1;
    strap = BSID_REV_C;
    n_mismatch = 0;
    check_count = 0;
    cycles = 0;
    build_exp = {BSID_BUILD_NUM, BSID_BUILD_REV, 9'h000, BSID_BUILD_CAPS,
                 BSID_BUILD_CNT};
    @(posedge pclk);
    do_reset();
    // Values after reset and the fixed identification fields.
    rd(BSID_OFS_SWITCH, 32'h0);
    rd(BSID_OFS_REV, {28'h0, BSID_REV_C});
    rd(BSID_OFS_BUILD, build_exp);
    check({31'h0, rdv[7:0] <= 8'h08}, 32'h1);
    rd(BSID_OFS_LOCK, 32'hFFFF0001);
    // Writes to read-only registers leave them unchanged.
    foreach (ro_tab[i]) wr(ro_tab[i], ro_wd[i], 1'b0);
    rd(BSID_OFS_SWITCH, 32'h0);
    rd(BSID_OFS_REV, {28'h0, BSID_REV_C});
    rd(BSID_OFS_BUILD, build_exp);
    // An unmapped word answers with an error and zero data.
    wr(12'h008, 32'h12345678, 1'b1);
    apb(1'b0, 12'h008, 32'h0, rdv, erv);
    check({erv, rdv[30:0]}, 32'h80000000);
    // Switch change raises a masked-in event; clear it by writing one.
    wr(BSID_OFS_IRQ_STAT, 32'h7, 1'b0);
    rd(BSID_OFS_IRQ_STAT, 32'h0);
    wr(BSID_OFS_IRQ_MASK, 32'h4, 1'b0);
    rd(BSID_OFS_IRQ_MASK, 32'h4);
    panel <= 8'h5A;
    repeat (2 * POLL + 8) @(posedge pclk);
    rd(BSID_OFS_SWITCH, 32'h5A);
    check({31'h0, irq}, 32'h1);
    rd(BSID_OFS_IRQ_STAT, 32'h4);
    wr(BSID_OFS_IRQ_STAT, 32'h4, 1'b0);
    check({31'h0, irq}, 32'h0);
    rd(BSID_OFS_IRQ_STAT, 32'h0);
    wr(BSID_OFS_IRQ_MASK, 32'h0, 1'b0);
    panel <= 8'h3C;
    repeat (2 * POLL + 8) @(posedge pclk);
    rd(BSID_OFS_IRQ_STAT, 32'h4);
    check({31'h0, irq}, 32'h0);
    // Mask and lock combinations feed the combined flag.
    foreach (m_tab[i]) begin
      loops <= l_tab[i];
      wr(BSID_OFS_LOCK, {m_tab[i], 24'h0}, 1'b0);
      repeat (4) @(posedge pclk);
      rd(BSID_OFS_LOCK, {m_tab[i], l_tab[i], 15'h0,
         &(l_tab[i] | ~m_tab[i])});
      check({31'h0, comb_flag}, {31'h0, &(l_tab[i] | ~m_tab[i])});
    end
    // A low clock enable freezes the flag until it rises again.
    pce <= 1'b0;
    loops <= 8'hFF;
    repeat (8) @(posedge pclk);
    check({31'h0, comb_flag}, 32'h0);
    pce <= 1'b1;
    repeat (5) @(posedge pclk);
    check({31'h0, comb_flag}, 32'h1);
    loops <= 8'hF0;
    strap <= BSID_REV_A;
    // A second reset restores the mask and clears the mirror.
    do_reset();
    rd(BSID_OFS_SWITCH, 32'h0);
    rd(BSID_OFS_IRQ_STAT, 32'h0);
    rd(BSID_OFS_REV, {28'h0, BSID_REV_A});
    rd(BSID_OFS_LOCK, {8'hFF, 8'hF0, 16'h0});
    stop_test();
  end
endmodule

// ---- verilog/bsid_irq.sv ----
// Sticky event status, mask and interrupt level for the bank.
`timescale 1ns/1ps
module bsid_irq
  import bsid_pkg::*;
(
  input  wire logic                  clk,       // System clock.
  input  wire logic                  rst_n,     // Async reset, active low.
  input  wire logic                  ce,        // Clock enable.
  input  wire logic [BSID_IRQ_W-1:0] event_i,   // One-cycle event pulses.
  input  wire logic                  clr_we,    // Write to status register.
  input  wire logic                  mask_we,   // Write to mask register.
  input  wire logic [BSID_IRQ_W-1:0] wdata,     // Bus write data.
  output logic      [BSID_IRQ_W-1:0] status_o,  // Sticky event bits.
  output logic      [BSID_IRQ_W-1:0] mask_o,    // Event enables.
  output logic                       irq_o      // Interrupt level.
);

  bsid_irq_state_t st_ff;  // Registered state.
  bsid_irq_state_t nxt_st; // Next state.

  // A new event wins over a write-one clear in the same cycle.
  always_comb begin
    nxt_st = st_ff;
    if (clr_we) begin
      nxt_st.status = st_ff.status & ~wdata;
    end
    nxt_st.status = nxt_st.status | event_i;
    if (mask_we) begin
      nxt_st.mask = wdata;
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  // Register the state; everything is zero after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign status_o = st_ff.status;
  assign mask_o   = st_ff.mask;
  assign irq_o    = st_ff.irq;

endmodule

// ---- verilog/bsid_regs.sv ----
// Board status and identification register bank with an APB slave.
//
// Contract
// - Switch levels read in bits seven to zero.
// - Software cannot change the switch register.
// - Revision code in low four bits.
// - Revision register ignores software writes.
// - Eight loop lock flags in bits 23:16.
// - Mask bit one includes its lock flag.
// - Bit zero set when all included loops locked.
// - Mask bits are writable and retained.
// - Build number in build register top byte.
// - Target board revision in bits 23:20.
// - Bits 10:8 flag supported query commands.
// - Low byte counts user registers, eight maximum.
// - Build register ignores software writes.
// - Bits clear to zero on reset; the mask bits reset to all ones instead.
`timescale 1ns/1ps
module bsid_regs
  import bsid_pkg::*;
(
  input  wire logic        pclk,            // System clock, 25 MHz.
  input  wire logic        presetn,         // Async reset, active low.
  input  wire logic        pce,             // Clock enable, freezes all.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB access phase.
  input  wire logic        pwrite,          // APB direction, high writes.
  input  wire logic [11:0] paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic      [31:0] prdata,          // APB read data.
  output logic             pready,          // APB transfer done.
  output logic             pslverr,         // APB error, unmapped.
  input  wire logic        mc_sw_we,        // Controller switch update.
  input  wire logic [7:0]  mc_toggle_levels, // Polled switch levels.
  input  wire logic [7:0]  loop_locked,     // Raw loop lock levels.
  input  wire logic [3:0]  board_rev_strap, // Board revision pins.
  output logic             irq,             // Interrupt, active high.
  output logic             combined_lock_flag // All included loops lock.
);

  bsid_state_t st_ff;  // Registered state of the bank.
  bsid_state_t nxt_st; // Next state of the bank.

  logic [7:0]            lock_sync;  // Synchronised lock flags.
  logic [3:0]            rev_sync;   // Synchronised revision strap.
  logic [BSID_IRQ_W-1:0] ev_status;  // Sticky event bits.
  logic [BSID_IRQ_W-1:0] ev_mask;    // Event enables.
  logic                  irq_lvl;    // Interrupt level from the unit.
  logic [BSID_IRQ_W-1:0] events;     // Event pulses this cycle.
  logic                  acc_start;  // First access cycle of a transfer.
  logic                  acc_done;   // Edge at which a transfer completes.
  logic                  wr_done;    // Completing write.
  logic                  mapped;     // Address hits a register.
  logic [31:0]           rd_word;    // Word selected for reading.
  logic [31:0]           lock_word;  // Loop lock register image.
  logic [31:0]           build_word; // Build register image.

  // Lock flags come from free-running loops in other domains.
  bsid_sync #(
    .W       (8)
  ) u_lock_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .ce      (pce),
    .async_i (loop_locked),
    .sync_o  (lock_sync)
  );

  // The revision straps are board pins and are synchronised too.
  bsid_sync #(
    .W       (4)
  ) u_rev_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .ce      (pce),
    .async_i (board_rev_strap),
    .sync_o  (rev_sync)
  );

  // Event status, mask and the interrupt level.
  bsid_irq u_irq (
    .clk      (pclk),
    .rst_n    (presetn),
    .ce       (pce),
    .event_i  (events),
    .clr_we   (wr_done && bsid_hit(paddr, BSID_OFS_IRQ_STAT)),
    .mask_we  (wr_done && bsid_hit(paddr, BSID_OFS_IRQ_MASK)),
    .wdata    (pwdata[BSID_IRQ_W-1:0]),
    .status_o (ev_status),
    .mask_o   (ev_mask),
    .irq_o    (irq_lvl)
  );

  // Bus phases: the answer comes one cycle into the access phase.
  assign acc_start = psel && penable && !st_ff.pready;
  assign acc_done  = psel && penable && st_ff.pready;
  assign wr_done   = acc_done && pwrite;

  // Register images assembled from the state and the fixed fields.
  always_comb begin
    lock_word = '0;
    lock_word[BSID_LOCK_MASK_LSB +: 8] = st_ff.mask;
    lock_word[BSID_LOCK_FLAG_LSB +: 8] = lock_sync;
    lock_word[BSID_LOCK_COMB_BIT]      = st_ff.comb;
    build_word = '0;
    build_word[BSID_BUILD_NUM_LSB +: 8] = BSID_BUILD_NUM;
    build_word[BSID_BUILD_REV_LSB +: 4] = BSID_BUILD_REV;
    build_word[BSID_BUILD_CAP_LSB +: 3] = BSID_BUILD_CAPS;
    build_word[BSID_BUILD_CNT_LSB +: 8] = BSID_BUILD_CNT;
  end

  // Read multiplexer; reserved bits read as zero and unmapped fail.
  always_comb begin
    rd_word = '0;
    mapped  = 1'b1;
    if (bsid_hit(paddr, BSID_OFS_SWITCH)) begin
      rd_word[7:0] = st_ff.sw;
    end else if (bsid_hit(paddr, BSID_OFS_REV)) begin
      rd_word[3:0] = st_ff.rev;
    end else if (bsid_hit(paddr, BSID_OFS_LOCK)) begin
      rd_word = lock_word;
    end else if (bsid_hit(paddr, BSID_OFS_BUILD)) begin
      rd_word = build_word;
    end else if (bsid_hit(paddr, BSID_OFS_IRQ_STAT)) begin
      rd_word[BSID_IRQ_W-1:0] = ev_status;
    end else if (bsid_hit(paddr, BSID_OFS_IRQ_MASK)) begin
      rd_word[BSID_IRQ_W-1:0] = ev_mask;
    end else begin
      mapped = 1'b0;
    end
  end

  // Next state of the bank.
  always_comb begin
    nxt_st = st_ff;
    // Answer one cycle into the access phase, for one cycle only.
    nxt_st.pready  = acc_start;
    nxt_st.pslverr = acc_start && !mapped;
    nxt_st.prdata  = (acc_start && !pwrite && mapped) ? rd_word : '0;
    // Only the controller port updates the switch mirror.
    if (mc_sw_we) begin
      nxt_st.sw = mc_toggle_levels;
    end
    // Strap capture waits until the synchroniser holds real levels.
    case (st_ff.rev_st)
      BSID_REV_WAIT1: begin
        nxt_st.rev_st = BSID_REV_WAIT2;
      end
      BSID_REV_WAIT2: begin
        // The second stage only shows the straps after this edge.
        nxt_st.rev_st = BSID_REV_WAIT3;
      end
      BSID_REV_WAIT3: begin
        nxt_st.rev_st = BSID_REV_HELD;
        nxt_st.rev    = rev_sync;
      end
      BSID_REV_HELD: begin
        nxt_st.rev_st = BSID_REV_HELD;
      end
      default: begin
        nxt_st.rev_st = BSID_REV_WAIT1;
      end
    endcase
    // Software may write only the mask field of the lock register.
    if (wr_done && bsid_hit(paddr, BSID_OFS_LOCK)) begin
      nxt_st.mask = pwdata[BSID_LOCK_MASK_LSB +: 8];
    end
    // Combined flag from present flags and mask, every cycle.
    nxt_st.comb = &(~st_ff.mask | lock_sync);
  end

  // Events raised by the bank itself.
  always_comb begin
    events = '0;
    events[BSID_EV_LOCK_LOST] = st_ff.comb && !nxt_st.comb;
    events[BSID_EV_LOCK_GAIN] = !st_ff.comb && nxt_st.comb;
    events[BSID_EV_SWITCH]    = mc_sw_we && (mc_toggle_levels != st_ff.sw);
  end

  // Register the bank; reset clears all but the mask bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff      <= '0;
      st_ff.mask <= BSID_RST_MASK;
    end else if (pce) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata             = st_ff.prdata;
  assign pready             = st_ff.pready;
  assign pslverr            = st_ff.pslverr;
  assign combined_lock_flag = st_ff.comb;
  assign irq                = irq_lvl;

  // Checks of the bank's behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Controller updates land in the switch register one edge later.
  sw_track_a: assert property (
    (pce && mc_sw_we) |=> (st_ff.sw == $past(mc_toggle_levels)))
    else $error("switch mirror missed a controller update");

  // Bus writes never move the switch mirror.
  sw_readonly_a: assert property (
    (pce && wr_done && !mc_sw_we && bsid_hit(paddr, BSID_OFS_SWITCH))
    |=> $stable(st_ff.sw))
    else $error("switch mirror changed on a bus write");

  // Once captured, the revision code stays put.
  rev_stable_a: assert property (
    (st_ff.rev_st == BSID_REV_HELD) |=> $stable(st_ff.rev))
    else $error("revision code changed after capture");

  // Build register reads return the fixed identification word.
  build_read_a: assert property (
    (pce && acc_start && !pwrite && bsid_hit(paddr, BSID_OFS_BUILD))
    |=> (prdata == 32'h03100708 && pready))
    else $error("build register read returned a wrong word");

  // Mask writes are kept until the next mask write.
  mask_keep_a: assert property (
    (pce && wr_done && bsid_hit(paddr, BSID_OFS_LOCK))
    |=> (st_ff.mask == $past(pwdata[31:24])))
    else $error("mask bits not retained after a write");

  // Combined flag follows flags and mask with one cycle of delay.
  comb_calc_a: assert property (
    pce |=> (combined_lock_flag ==
             $past((lock_sync | ~st_ff.mask) == 8'hFF)))
    else $error("combined lock flag disagrees with flags and mask");

  // Lock reads show the synchronised flags in bits 23:16.
  lock_read_a: assert property (
    (pce && acc_start && !pwrite && bsid_hit(paddr, BSID_OFS_LOCK))
    |=> (prdata[23:16] == $past(lock_sync) && prdata[15:1] == 15'h0000))
    else $error("lock register read shows wrong flags");

  // A transfer is answered exactly one cycle into its access phase.
  bus_answer_a: assert property (
    (pce && acc_start) |=> (pready ##1 !pready || !pce))
    else $error("access phase not answered in one cycle");

  // Interrupt is high exactly while an enabled event is pending.
  irq_level_a: assert property (
    (irq == |(ev_status & ev_mask)))
    else $error("interrupt level disagrees with status and mask");

  // A changed switch mirror always leaves its sticky event bit set.
  ev_switch_a: assert property (
    (pce && mc_sw_we && (mc_toggle_levels != st_ff.sw))
    |=> ev_status[BSID_EV_SWITCH])
    else $error("switch change did not set its event bit");

  // Main scenarios that the bench should reach.
  cov_lock_lost_c: cover property (
    combined_lock_flag ##1 !combined_lock_flag);
  cov_mask_write_c: cover property (
    wr_done && bsid_hit(paddr, BSID_OFS_LOCK));
  cov_unmapped_c: cover property (pready && pslverr);
  cov_irq_c: cover property (!irq ##1 irq);

endmodule

// ---- verilog/bsid_sync.sv ----
// Two-stage synchroniser for a vector of slow asynchronous levels.
`timescale 1ns/1ps
module bsid_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,    // System clock.
  input  wire logic         rst_n,  // Asynchronous reset, active low.
  input  wire logic         ce,     // Clock enable, freezes stages.
  input  wire logic [W-1:0] async_i, // Levels from another domain.
  output logic      [W-1:0] sync_o   // Levels safe to use here.
);

  // Both stages form the whole state; stage one feeds stage two only.
  typedef struct packed {
    logic [W-1:0] s2; // Second stage, read by logic.
    logic [W-1:0] s1; // First stage, may be metastable.
  } sync_state_t;

  sync_state_t st_ff;  // Registered stages.
  sync_state_t nxt_st; // Next value of the stages.

  // Shift the levels one stage per enabled edge.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = async_i;
    nxt_st.s2 = st_ff.s1;
  end

  // Register the stages; reset clears them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.s2;

endmodule
